// ### bench/rxt_card.sv
// ****
// remote card or peer
// ****
module rxt_card #(
	parameter REPLY_CYC = 100
) (
	input wire logic clock,         // clock
	input wire logic tx_active,     // our carrier
	input wire logic reply_en,      // card answers
	input wire logic field_en,      // peer field on
	output logic     rx_start,      // reply seen
	output logic     ext_field_pin  // peer field
);
	timeunit 1ns;
	timeprecision 1ns;
	logic tx_q = 1'b0;
	int   cnt = 0;
	initial rx_start = 1'b0;
	assign ext_field_pin = field_en;
	// answers once, a fixed delay after our carrier drops
	always @(posedge clock) begin
		tx_q <= tx_active;
		rx_start <= 1'b0;
		if (tx_q && !tx_active && reply_en)
			cnt <= REPLY_CYC;
		else if (cnt > 0) begin
			cnt <= cnt - 1;
			rx_start <= (cnt == 1);
		end
	end
endmodule

// ### bench/rxt_timers_sva.sv
`include "rxt_defs.vh"
// ****
// checker
// ****
module rxt_chk #(
	parameter SLEEP_CYC = 20
) (
	input wire logic        clock,           // clock
	input wire logic        rst,             // reset
	input wire logic [7:0]  avs_address,     // addr
	input wire logic        avs_read,        // rd
	input wire logic        avs_write,       // wr
	input wire logic [31:0] avs_writedata,   // wdata
	input wire logic [3:0]  avs_byteenable,  // lanes
	input wire logic        avs_waitrequest, // stall
	input wire logic        tx_active,       // tx on
	input wire logic        corr_pulse,      // corr out
	input wire logic        rx_start,        // reply
	input wire logic        rx_mask_q,       // mask
	input wire logic        nrt_event_q,     // timeout
	input wire logic        nrt_run_q,       // running
	input wire logic        corr_sleep_q,    // asleep
	input wire logic        corr_stream_q    // stream
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	logic [15:0] quiet_q;
	// awake cycles since last pulse, saturating
	always_ff @(posedge clock or posedge rst) begin
		if (rst)
			quiet_q <= 16'h0000;
		else if (corr_pulse || corr_sleep_q)
			quiet_q <= 16'h0000;
		else if (quiet_q != 16'hFFFF)
			quiet_q <= quiet_q + 16'h0001;
	end
	sequence s_req; (avs_read || avs_write) && avs_waitrequest; endsequence
	sequence s_cfg_wr;
		avs_write && !avs_waitrequest && avs_byteenable[0] && avs_address == {`RXT_IDX_CORR_CFG2, 2'b00};
	endsequence
	sequence s_cancel; rx_start && nrt_run_q; endsequence
	property p_wait_one; !avs_waitrequest |=> avs_waitrequest; endproperty
	a_wait_one: assert property (p_wait_one) else $error("waitrequest low two cycles");
	property p_wait_ans; s_req |=> !avs_waitrequest; endproperty
	a_wait_ans: assert property (p_wait_ans) else $error("request not answered");
	property p_stream; s_cfg_wr |-> ##2 corr_stream_q == $past(avs_writedata[0], 2); endproperty
	a_stream: assert property (p_stream) else $error("stream bit not applied");
	property p_mask_rise; $fell(tx_active) |=> rx_mask_q; endproperty
	a_mask_rise: assert property (p_mask_rise) else $error("mask not raised");
	property p_mask_min; $rose(rx_mask_q) |-> rx_mask_q [*8]; endproperty
	a_mask_min: assert property (p_mask_min) else $error("mask too short");
	property p_evt_pulse; nrt_event_q |=> !nrt_event_q; endproperty
	a_evt_pulse: assert property (p_evt_pulse) else $error("timeout pulse too long");
	property p_evt_run; nrt_event_q |-> $past(nrt_run_q); endproperty
	a_evt_run: assert property (p_evt_run) else $error("timeout without run");
	property p_cancel; s_cancel |-> ##[1:2] !nrt_run_q; endproperty
	a_cancel: assert property (p_cancel) else $error("reply did not stop timer");
	property p_sleep_late; quiet_q == SLEEP_CYC + 4 |-> corr_sleep_q; endproperty
	a_sleep_late: assert property (p_sleep_late) else $error("correlator did not sleep");
	property p_sleep_early; $rose(corr_sleep_q) |-> quiet_q >= SLEEP_CYC - 2; endproperty
	a_sleep_early: assert property (p_sleep_early) else $error("correlator slept early");
endmodule

bind rxt_timers rxt_chk #(.SLEEP_CYC(SLEEP_CYC)) chk_u (.clock, .rst, .avs_address, .avs_read, .avs_write,
	.avs_writedata, .avs_byteenable, .avs_waitrequest, .tx_active, .corr_pulse, .rx_start, .rx_mask_q,
	.nrt_event_q, .nrt_run_q, .corr_sleep_q, .corr_stream_q);

// ### bench/test_rx_mask_and_noresponse_timers.sv
`include "rxt_defs.vh"
module test_rx_mask_and_noresponse_timers;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clock = 1'b0, rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0, tx_active = 1'b0;
	logic        rx_on = 1'b0, corr_pulse = 1'b0, reply_en = 1'b0, field_en = 1'b0;
	logic [7:0]  avs_address = 8'h00, q;
	logic [31:0] avs_writedata = 32'h0, avs_readdata;
	logic [3:0]  avs_byteenable = 4'hF;
	logic        avs_waitrequest, rx_start, ext_field_pin, rx_mask_q, nrt_event_q, nrt_run_q;
	logic        corr_sleep_q, corr_stream_q;
	int          mismatches = 0, n_checks = 0, n;
	rxt_timers #(.SLEEP_CYC(20), .WAKE_SHORT_CYC(20), .WAKE_LONG_CYC(40)) dut_u (.clock, .rst, .avs_address,
		.avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .tx_active,
		.rx_on, .corr_pulse, .rx_start, .ext_field_pin, .rx_mask_q, .nrt_event_q, .nrt_run_q, .corr_sleep_q,
		.corr_stream_q);
	rxt_card card_u (.clock, .tx_active, .reply_en, .field_en, .rx_start, .ext_field_pin);
	initial begin
		forever #5 clock = ~clock;
	end
	// ****
	// helpers
	// ****
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic conclude;
		$display("checks=%0d mismatches=%0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// request held until the edge that samples waitrequest low; data taken there
	task automatic acc(input logic [5:0] idx, input logic w, input logic [7:0] d, input logic [3:0] be);
		int i;
		@(posedge clock);
		avs_address <= {idx, 2'b00};
		avs_write <= w;
		avs_read <= !w;
		avs_writedata <= {24'h0, d};
		avs_byteenable <= be;
		i = 0;
		do begin
			@(posedge clock);
			i++;
		end while (avs_waitrequest !== 1'b0 && i < 100);
		if (avs_waitrequest !== 1'b0) begin
			mismatches++;
			conclude();
		end
		q = avs_readdata[7:0];
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask
	task automatic wr(input logic [5:0] idx, input logic [7:0] d);
		acc(idx, 1'b1, d, 4'hF);
	endtask
	task automatic rdc(input logic [5:0] idx, input logic [7:0] exp);
		acc(idx, 1'b0, 8'h00, 4'hF);
		check(q, exp);
	endtask
	function automatic logic pick(input int s);
		case (s)
			0: return rx_mask_q;
			1: return nrt_event_q;
			2: return nrt_run_q;
			default: return corr_sleep_q;
		endcase
	endfunction
	task automatic wait_for(input int s, input logic v, input int lim);
		n = 0;
		do begin
			@(negedge clock);
			n++;
			if (n > lim) begin
				mismatches++;
				conclude();
			end
		end while (pick(s) !== v);
	endtask
	task automatic stays_low(input int s, input int cyc);
		logic seen;
		seen = 1'b0;
		repeat (cyc) begin
			@(negedge clock);
			seen = seen | pick(s);
		end
		check(seen, 1'b0);
	endtask
	// carrier ticks jitter by a clock, so durations get a small window
	task automatic near(input int exp);
		check((n > exp - 5 && n < exp + 5) ? exp : n, exp);
	endtask
	// first counted tick lands 1 to 8 clocks after a start, so centre on the middle
	function automatic int clk(input int ticks);
		return (ticks - 1) * `RXT_FC_DEN / `RXT_FC_NUM + 5;
	endfunction
	task automatic txend;
		@(posedge clock);
		tx_active <= 1'b1;
		@(posedge clock);
		tx_active <= 1'b0;
	endtask
	// ****
	// sequence
	// ****
	logic [7:0] mv[3] = '{8'h02, 8'h01, 8'h09};
	logic [7:0] mc[3] = '{8'h00, 8'h08, 8'h00};
	int         tk[3] = '{256, 2048, 576};
	logic [7:0] sc[3] = '{8'h00, 8'h00, 8'h02};
	logic [7:0] sm[3] = '{8'h00, 8'h02, 8'h00};
	int         se[3] = '{20, 40, 1};
	initial begin
		repeat (3) @(posedge clock);
		rst <= 1'b0;
		rdc(`RXT_IDX_CORR_CFG2, 8'h00);
		rdc(`RXT_IDX_MASK_TIME, 8'h08);
		rdc(`RXT_IDX_NRT_HIGH, 8'h00);
		rdc(`RXT_IDX_NRT_LOW, 8'h00);
		wr(`RXT_IDX_CORR_CFG2, 8'hFF);
		rdc(`RXT_IDX_CORR_CFG2, 8'h03);
		check(corr_stream_q, 1'b1);
		wr(`RXT_IDX_TMR_CTL, 8'hFF);
		rdc(`RXT_IDX_TMR_CTL, 8'h09);
		wr(`RXT_IDX_NRT_HIGH, 8'hA5);
		rdc(`RXT_IDX_NRT_HIGH, 8'hA5);
		acc(`RXT_IDX_MASK_TIME, 1'b1, 8'h33, 4'hE);
		rdc(`RXT_IDX_MASK_TIME, 8'h08);
		rdc(6'h3F, 8'h00);
		wr(`RXT_IDX_NRT_HIGH, 8'h00);
		for (int i = 0; i < 3; i++) begin
			wr(`RXT_IDX_TMR_CTL, mc[i]);
			wr(`RXT_IDX_MASK_TIME, mv[i]);
			txend();
			wait_for(0, 1'b1, 3);
			wait_for(0, 1'b0, 20000);
			near(clk(tk[i]));
		end
		txend();
		stays_low(2, 50);
		wr(`RXT_IDX_NRT_LOW, 8'h02);
		txend();
		wait_for(1, 1'b1, 5000);
		near(clk(128) + 2);
		rdc(`RXT_IDX_STATUS, 8'h0D);
		wr(`RXT_IDX_STATUS, 8'h04);
		rdc(`RXT_IDX_STATUS, 8'h09);
		txend();
		wr(`RXT_IDX_NRT_LOW, 8'h04);
		wait_for(1, 1'b1, 5000);
		near(clk(128) - 1);
		wr(`RXT_IDX_NRT_LOW, 8'h02);
		wr(`RXT_IDX_COMMAND, 8'h01);
		repeat (300) @(posedge clock);
		wr(`RXT_IDX_COMMAND, 8'h01);
		wait_for(1, 1'b1, 5000);
		near(clk(128) + 1);
		reply_en <= 1'b1;
		txend();
		stays_low(1, 1200);
		reply_en <= 1'b0;
		wr(`RXT_IDX_MODE, 8'h01);
		txend();
		stays_low(2, 100);
		@(posedge clock);
		field_en <= 1'b1;
		wait_for(2, 1'b1, 20);
		near(6);
		wait_for(1, 1'b1, 5000);
		field_en <= 1'b0;
		wr(`RXT_IDX_MODE, 8'h00);
		wr(`RXT_IDX_TMR_CTL, 8'h01);
		wr(`RXT_IDX_NRT_LOW, 8'h01);
		txend();
		wait_for(1, 1'b1, 40000);
		near(clk(4096) + 2);
		for (int i = 0; i < 3; i++) begin
			wr(`RXT_IDX_CORR_CFG2, sc[i]);
			wr(`RXT_IDX_MODE, sm[i]);
			check(corr_stream_q, sc[i][0]);
			wait_for(3, 1'b1, 100);
			@(posedge clock);
			rx_on <= 1'b1;
			wait_for(3, 1'b0, 100);
			near(se[i]);
			@(posedge clock);
			rx_on <= 1'b0;
			corr_pulse <= 1'b1;
			@(posedge clock);
			corr_pulse <= 1'b0;
			wait_for(3, 1'b1, 100);
			near(20);
		end
		conclude();
	end
endmodule

// ### hw/rxt_defs.vh
`ifndef RXT_DEFS_VH
`define RXT_DEFS_VH

// ****************************************
// register indices (byte address = index * 4)
// ****************************************
`define RXT_IDX_CORR_CFG2   6'h0D
`define RXT_IDX_MASK_TIME   6'h0F
`define RXT_IDX_NRT_HIGH    6'h10
`define RXT_IDX_NRT_LOW     6'h11
`define RXT_IDX_TMR_CTL     6'h12
`define RXT_IDX_MODE        6'h20
`define RXT_IDX_COMMAND     6'h21
`define RXT_IDX_STATUS      6'h22

// ****************************************
// field positions
// ****************************************
`define RXT_CORR_STREAM_BIT 0
`define RXT_CORR_EXIT_BIT   1
`define RXT_TMR_NRT_STEP    0
`define RXT_TMR_MRT_STEP    3
`define RXT_MODE_NFC_BIT    0
`define RXT_MODE_LONG_BIT   1
`define RXT_CMD_NRT_START   0
`define RXT_ST_MASK_BIT     0
`define RXT_ST_NRT_RUN_BIT  1
`define RXT_ST_NRT_EXP_BIT  2
`define RXT_ST_SLEEP_BIT    3

// ****************************************
// reset values
// ****************************************
`define RXT_RST_CORR_CFG2   2'h0
`define RXT_RST_MASK_TIME   8'h08
`define RXT_RST_NRT_HIGH    8'h00
`define RXT_RST_NRT_LOW     8'h00
`define RXT_RST_TMR_CTL     2'h0
`define RXT_RST_MODE        2'h0

// ****************************************
// timing, in carrier periods and ns
// ****************************************
`define RXT_MRT_MIN_UNITS   8'h04
`define RXT_MRT_STEP0_FC    12'h03F
`define RXT_MRT_STEP1_FC    12'h1FF
`define RXT_NRT_STEP0_FC    12'h03F
`define RXT_NRT_STEP1_FC    12'hFFF
`define RXT_CLK_MHZ         100
`define RXT_SLEEP_NS        18000
`define RXT_WAKE_SHORT_NS   18000
`define RXT_WAKE_LONG_NS    42000
`define RXT_NS_TO_CYC(ns)   (((ns) * `RXT_CLK_MHZ + 999) / 1000)
`define RXT_FC_NUM          1356
`define RXT_FC_DEN          10000

`endif

// ### hw/rxt_fc_tick.v
`include "rxt_defs.vh"

// ****************************************
// carrier period tick from the system clock
// ****************************************
// phase accumulator: average rate is exact, single ticks jitter by one clock
module rxt_fc_tick #(
	parameter NUM = `RXT_FC_NUM,
	parameter DEN = `RXT_FC_DEN
) (
	input  wire clock,   // system clock
	input  wire rst,     // async reset, high
	output reg  tick_q   // one pulse per carrier period
);
	reg  [15:0] acc_q;
	wire [16:0] sum = {1'b0, acc_q} + NUM[16:0];

	always @(posedge clock or posedge rst) begin
		if (rst) begin
			acc_q  <= 16'h0000;
			tick_q <= 1'b0;
		end else if (sum >= DEN[16:0]) begin
			acc_q  <= sum[15:0] - DEN[15:0];
			tick_q <= 1'b1;
		end else begin
			acc_q  <= sum[15:0];
			tick_q <= 1'b0;
		end
	end
endmodule

// ### hw/rxt_timers.v
`include "rxt_defs.vh"

// How it works
// - stream bit selects 424 kHz correlator mode
// - exit bit: timer wake or receiver-on wake
// - correlator sleeps after 18 us silence
// - timed wake takes 18 or 42 us
// - receiver output masked after transmission ends
// - mask step 64 carrier periods
// - mask step 512 carrier periods
// - mask never shorter than four steps
// - sixteen-bit no-response value, high/low bytes
// - no-response timeout raises no-response event
// - no-response step 64 carrier periods
// - no-response step 4096 carrier periods
// - nfc mode starts only with field or start command
// - other modes start automatically when transmitter turns off
// - zero value never starts no-response timer
// - start command resets and restarts timer
// - mask step select is control bit 3
// - no-response step select is control bit 0
module rxt_timers #(
	parameter SLEEP_CYC      = `RXT_NS_TO_CYC(`RXT_SLEEP_NS),
	parameter WAKE_SHORT_CYC = `RXT_NS_TO_CYC(`RXT_WAKE_SHORT_NS),
	parameter WAKE_LONG_CYC  = `RXT_NS_TO_CYC(`RXT_WAKE_LONG_NS)
) (
	input  wire        clock,               // system clock, 100 MHz
	input  wire        rst,                 // async reset, high
	input  wire [7:0]  avs_address,         // byte address
	input  wire        avs_read,            // read request
	input  wire        avs_write,           // write request
	input  wire [31:0] avs_writedata,       // write data
	input  wire [3:0]  avs_byteenable,      // byte lanes
	output reg  [31:0] avs_readdata,        // read data
	output reg         avs_waitrequest,     // stall
	input  wire        tx_active,           // transmitter on
	input  wire        rx_on,               // receiver active flag
	input  wire        corr_pulse,          // correlator output pulse
	input  wire        rx_start,            // response detected
	input  wire        ext_field_pin,       // external field detector, async
	output reg         rx_mask_q,           // receiver output ignored
	output reg         nrt_event_q,         // no-response timeout pulse
	output reg         nrt_run_q,           // no-response timer counting
	output reg         corr_sleep_q,        // correlator asleep
	output reg         corr_stream_q        // 424 kHz stream mode
);
	// ****************************************
	// declarations
	// ****************************************
	localparam NRT_IDLE = 2'b00;
	localparam NRT_WAIT = 2'b01;
	localparam NRT_RUN  = 2'b10;
	localparam CS_AWAKE = 2'b00;
	localparam CS_SLEEP = 2'b01;
	localparam CS_WAKE  = 2'b10;

	reg  [1:0]  corr_cfg_q;
	reg  [7:0]  mask_time_q;
	reg  [7:0]  nrt_high_q;
	reg  [7:0]  nrt_low_q;
	reg  [1:0]  tmr_ctl_q;
	reg  [1:0]  mode_q;
	reg         nrt_flag_q;
	reg         tx_q;
	reg         fld1_q;
	reg         fld2_q;
	reg         fld3_q;
	reg         field_q;
	reg  [7:0]  mask_cnt_q;
	reg  [11:0] mask_pre_q;
	reg  [11:0] mask_last_q;
	reg  [1:0]  nrt_st_q;
	reg  [15:0] nrt_cnt_q;
	reg  [11:0] nrt_pre_q;
	reg  [11:0] nrt_last_q;
	reg  [1:0]  cs_q;
	reg  [15:0] quiet_q;
	reg  [15:0] wake_q;
	wire        fc_tick;

	wire [5:0]  reg_idx  = avs_address[7:2];
	wire        wr_en    = avs_write & ~avs_waitrequest & avs_byteenable[0];
	wire        tx_end   = tx_q & ~tx_active;
	wire [15:0] nrt_val  = {nrt_high_q, nrt_low_q};
	wire        cmd_start = wr_en && reg_idx == `RXT_IDX_COMMAND && avs_writedata[`RXT_CMD_NRT_START];
	wire        nrt_zero = (nrt_val == 16'h0000);
	wire        st_clear = wr_en && reg_idx == `RXT_IDX_STATUS && avs_writedata[`RXT_ST_NRT_EXP_BIT];
	wire        nrt_done = nrt_st_q == NRT_RUN && fc_tick && nrt_pre_q == nrt_last_q && nrt_cnt_q == 16'h0001;

	// ****************************************
	// register read decode
	// ****************************************
	function [7:0] reg_read;
		input [5:0] idx;
		begin
			case (idx)
				`RXT_IDX_CORR_CFG2: reg_read = {6'h00, corr_cfg_q};
				`RXT_IDX_MASK_TIME: reg_read = mask_time_q;
				`RXT_IDX_NRT_HIGH:  reg_read = nrt_high_q;
				`RXT_IDX_NRT_LOW:   reg_read = nrt_low_q;
				`RXT_IDX_TMR_CTL:   reg_read = {4'h0, tmr_ctl_q[1], 2'h0, tmr_ctl_q[0]};
				`RXT_IDX_MODE:      reg_read = {6'h00, mode_q};
				`RXT_IDX_STATUS:    reg_read = {4'h0, corr_sleep_q, nrt_flag_q, nrt_run_q, rx_mask_q};
				default:            reg_read = 8'h00;
			endcase
		end
	endfunction

	// ****************************************
	// carrier tick
	// ****************************************
	rxt_fc_tick u_fc (
		.clock  (clock),
		.rst    (rst),
		.tick_q (fc_tick)
	);

	// ****************************************
	// avalon slave, one wait state
	// ****************************************
	always @(posedge clock or posedge rst) begin
		if (rst) begin
			avs_waitrequest <= 1'b1;
			avs_readdata    <= 32'h00000000;
		end else if ((avs_read | avs_write) & avs_waitrequest) begin
			avs_waitrequest <= 1'b0;
			avs_readdata    <= {24'h000000, reg_read(reg_idx)};
		end else begin
			avs_waitrequest <= 1'b1;
		end
	end

	// ****************************************
	// register file
	// ****************************************
	always @(posedge clock or posedge rst) begin
		if (rst) begin
			corr_cfg_q  <= `RXT_RST_CORR_CFG2;
			mask_time_q <= `RXT_RST_MASK_TIME;
			nrt_high_q  <= `RXT_RST_NRT_HIGH;
			nrt_low_q   <= `RXT_RST_NRT_LOW;
			tmr_ctl_q   <= `RXT_RST_TMR_CTL;
			mode_q      <= `RXT_RST_MODE;
		end else if (wr_en) begin
			case (reg_idx)
				`RXT_IDX_CORR_CFG2: corr_cfg_q <= avs_writedata[1:0];
				`RXT_IDX_MASK_TIME: mask_time_q <= avs_writedata[7:0];
				`RXT_IDX_NRT_HIGH:  nrt_high_q <= avs_writedata[7:0];
				`RXT_IDX_NRT_LOW:   nrt_low_q <= avs_writedata[7:0];
				`RXT_IDX_TMR_CTL: begin
					tmr_ctl_q[1] <= avs_writedata[`RXT_TMR_MRT_STEP];
					tmr_ctl_q[0] <= avs_writedata[`RXT_TMR_NRT_STEP];
				end
				`RXT_IDX_MODE:      mode_q <= avs_writedata[1:0];
				default: begin
				end
			endcase
		end
	end

	// ****************************************
	// stream select
	// ****************************************
	// stream select drives the correlator from its register bit, registered one clock later
	always @(posedge clock or posedge rst) begin
		if (rst)
			corr_stream_q <= 1'b0;
		else
			corr_stream_q <= corr_cfg_q[`RXT_CORR_STREAM_BIT];
	end

	// ****************************************
	// field synchroniser, change needs two agreeing stages
	// ****************************************
	always @(posedge clock or posedge rst) begin
		if (rst) begin
			fld1_q  <= 1'b0;
			fld2_q  <= 1'b0;
			fld3_q  <= 1'b0;
			field_q <= 1'b0;
			tx_q    <= 1'b0;
		end else begin
			fld1_q <= ext_field_pin;
			fld2_q <= fld1_q;
			fld3_q <= fld2_q;
			if (fld2_q == fld3_q)
				field_q <= fld3_q;
			tx_q <= tx_active;
		end
	end

	// ****************************************
	// mask receive timer
	// ****************************************
	always @(posedge clock or posedge rst) begin
		if (rst) begin
			rx_mask_q   <= 1'b0;
			mask_cnt_q  <= 8'h00;
			mask_pre_q  <= 12'h000;
			mask_last_q <= `RXT_MRT_STEP0_FC;
		end else if (tx_end) begin
			rx_mask_q  <= 1'b1;
			mask_pre_q <= 12'h000;
			// value and step are latched here, later writes wait for next end of TX
			if (mask_time_q < `RXT_MRT_MIN_UNITS)
				mask_cnt_q <= `RXT_MRT_MIN_UNITS;
			else
				mask_cnt_q <= mask_time_q;
			if (tmr_ctl_q[1])
				mask_last_q <= `RXT_MRT_STEP1_FC;
			else
				mask_last_q <= `RXT_MRT_STEP0_FC;
		end else if (rx_mask_q && fc_tick) begin
			if (mask_pre_q == mask_last_q) begin
				mask_pre_q <= 12'h000;
				mask_cnt_q <= mask_cnt_q - 8'h01;
				if (mask_cnt_q == 8'h01)
					rx_mask_q <= 1'b0;
			end else begin
				mask_pre_q <= mask_pre_q + 12'h001;
			end
		end
	end

	// ****************************************
	// no-response timer
	// ****************************************
	always @(posedge clock or posedge rst) begin
		if (rst) begin
			nrt_st_q    <= NRT_IDLE;
			nrt_cnt_q   <= 16'h0000;
			nrt_pre_q   <= 12'h000;
			nrt_last_q  <= `RXT_NRT_STEP0_FC;
			nrt_run_q   <= 1'b0;
			nrt_event_q <= 1'b0;
		end else begin
			nrt_event_q <= nrt_done;
			if ((cmd_start || (tx_end && !mode_q[`RXT_MODE_NFC_BIT]) ||
				(nrt_st_q == NRT_WAIT && field_q)) && !nrt_zero) begin
				// restart wipes any count in progress
				nrt_st_q  <= NRT_RUN;
				nrt_run_q <= 1'b1;
				nrt_cnt_q <= nrt_val;
				nrt_pre_q <= 12'h000;
				if (tmr_ctl_q[0])
					nrt_last_q <= `RXT_NRT_STEP1_FC;
				else
					nrt_last_q <= `RXT_NRT_STEP0_FC;
			end else if (tx_end && !nrt_zero) begin
				nrt_st_q  <= NRT_WAIT;
				nrt_run_q <= 1'b0;
			end else begin
				case (nrt_st_q)
					NRT_WAIT: begin
						if (rx_start)
							nrt_st_q <= NRT_IDLE;
					end
					NRT_RUN: begin
						if (rx_start) begin
							nrt_st_q  <= NRT_IDLE;
							nrt_run_q <= 1'b0;
						end else if (nrt_done) begin
							nrt_st_q  <= NRT_IDLE;
							nrt_run_q <= 1'b0;
						end else if (fc_tick) begin
							if (nrt_pre_q == nrt_last_q) begin
								nrt_pre_q <= 12'h000;
								nrt_cnt_q <= nrt_cnt_q - 16'h0001;
							end else begin
								nrt_pre_q <= nrt_pre_q + 12'h001;
							end
						end
					end
					default: nrt_st_q <= NRT_IDLE;
				endcase
			end
		end
	end

	// ****************************************
	// timeout flag
	// ****************************************
	// sticky timeout flag, a new timeout beats a same-cycle clear
	always @(posedge clock or posedge rst) begin
		if (rst)
			nrt_flag_q <= 1'b0;
		else if (nrt_done)
			nrt_flag_q <= 1'b1;
		else if (st_clear)
			nrt_flag_q <= 1'b0;
	end

	// ****************************************
	// correlator sleep control
	// ****************************************
	always @(posedge clock or posedge rst) begin
		if (rst) begin
			cs_q         <= CS_AWAKE;
			quiet_q      <= 16'h0000;
			wake_q       <= 16'h0000;
			corr_sleep_q <= 1'b0;
		end else begin
			case (cs_q)
				CS_AWAKE: begin
					if (corr_pulse) begin
						quiet_q <= 16'h0000;
					end else if (quiet_q == SLEEP_CYC[15:0] - 16'h0001) begin
						quiet_q      <= 16'h0000;
						cs_q         <= CS_SLEEP;
						corr_sleep_q <= 1'b1;
					end else begin
						quiet_q <= quiet_q + 16'h0001;
					end
				end
				CS_SLEEP: begin
					if (rx_on && corr_cfg_q[`RXT_CORR_EXIT_BIT]) begin
						cs_q         <= CS_AWAKE;
						corr_sleep_q <= 1'b0;
					end else if (rx_on) begin
						cs_q <= CS_WAKE;
						// slow standards need the longer settling time
						if (mode_q[`RXT_MODE_LONG_BIT])
							wake_q <= WAKE_LONG_CYC[15:0] - 16'h0001;
						else
							wake_q <= WAKE_SHORT_CYC[15:0] - 16'h0001;
					end
				end
				CS_WAKE: begin
					if (wake_q == 16'h0000) begin
						cs_q         <= CS_AWAKE;
						corr_sleep_q <= 1'b0;
					end else begin
						wake_q <= wake_q - 16'h0001;
					end
				end
				default: begin
					cs_q         <= CS_AWAKE;
					corr_sleep_q <= 1'b0;
				end
			endcase
		end
	end
endmodule
